// ---- fdi_regs.vh ----
// field positions, codes and timing constants for the drive interface
`ifndef FDI_REGS_VH
`define FDI_REGS_VH

// drive output register fields
`define FDI_DOR_SEL0_BIT   0
`define FDI_DOR_SEL1_BIT   1
`define FDI_DOR_MOTOR_ON_FIRST_BIT   4
`define FDI_DOR_MOTOR_ON_SECOND_BIT   5
`define FDI_DOR_RST        8'h00

// controller configuration register: density polarity
`define FDI_CFG_DPOL_BIT   5

// data rate codes in bits 1:0 of the rate registers
`define FDI_RATE_500K      2'h0
`define FDI_RATE_300K      2'h1
`define FDI_RATE_250K      2'h2
`define FDI_RATE_1M        2'h3
`define FDI_RATE_RST       2'h0

// digital input register: door changed bit
`define FDI_DIR_CHG_BIT    7

// clock and timing
`define FDI_MCLK_MHZ       250
`define FDI_STEP_PW_NS     1000
`define FDI_STEP_MS_CYC    250000
`define FDI_PWR_HOLD_US    100
`define FDI_PC_NOM         8

`endif

// ---- fdi_drive_if.v ----
// drive-side signal logic of the floppy controller
`timescale 1ns/10ps
`include "fdi_regs.vh"

module fdi_drive_if
#(
  parameter STEP_MS_CYC = `FDI_STEP_MS_CYC,
  parameter PWR_HOLD_CYC = `FDI_PWR_HOLD_US * `FDI_MCLK_MHZ
)
(
  mclk,
  reset,
  dor_wr,
  dor_data,
  cfg_reg,
  ccr_wr,
  ccr_data,
  dsr_wr,
  dsr_data,
  force_wp,
  diag_mode,
  seek_go,
  seek_inward,
  seek_steps,
  step_rate,
  rw_active,
  head_side,
  write_enable_out_req,
  wr_flux,
  pc_early,
  pc_late,
  pc_amount,
  power_ok,
  index_n_in,
  track_zero_in,
  wprot_n_in,
  door_changed_in,
  rdata_n_in,
  density_select_out,
  rate_bit_out,
  drive_select_first,
  drive_select_second,
  motor_on_first,
  motor_on_second,
  side_select_out,
  dir_n_out,
  step_n_out,
  write_enable_out,
  wdata_n_out,
  seek_busy,
  index_sync,
  track_zero_sync,
  wprot_sync,
  input_reg,
  separator_gate_diag,
  rdata_sync
);
  input              mclk;
  input              reset;
  input              dor_wr;
  input      [7:0]   dor_data;
  input      [7:0]   cfg_reg;
  input              ccr_wr;
  input      [7:0]   ccr_data;
  input              dsr_wr;
  input      [7:0]   dsr_data;
  input              force_wp;
  input              diag_mode;
  input              seek_go;
  input              seek_inward;
  input      [7:0]   seek_steps;
  input      [3:0]   step_rate;
  input              rw_active;
  input              head_side;
  input              write_enable_out_req;
  input              wr_flux;
  input              pc_early;
  input              pc_late;
  input      [2:0]   pc_amount;
  input              power_ok;
  input              index_n_in;
  input              track_zero_in;
  input              wprot_n_in;
  input              door_changed_in;
  input              rdata_n_in;
  output reg         density_select_out;
  output reg         rate_bit_out;
  output reg         drive_select_first;
  output reg         drive_select_second;
  output reg         motor_on_first;
  output reg         motor_on_second;
  output reg         side_select_out;
  output reg         dir_n_out;
  output reg         step_n_out;
  output reg         write_enable_out;
  output reg         wdata_n_out;
  output reg         seek_busy;
  output reg         index_sync;
  output reg         track_zero_sync;
  output reg         wprot_sync;
  output reg [7:0]   input_reg;
  output reg         separator_gate_diag;
  output reg         rdata_sync;

  localparam STEP_PW_CYC =
    (`FDI_STEP_PW_NS * `FDI_MCLK_MHZ + 999) / 1000;
  localparam [2:0] SK_IDLE  = 3'h1;
  localparam [2:0] SK_PULSE = 3'h2;
  localparam [2:0] SK_GAP   = 3'h4;

  // step spacing: (16 - rate) milliseconds, as on classic controllers
  function [31:0] gap_cycles;
    input [3:0] rate;
    begin
      gap_cycles = (32'd16 - {28'h0, rate}) * STEP_MS_CYC;
    end
  endfunction

  // precompensation tap: nominal delay moved by the chosen amount
  function [3:0] pc_tap;
    input       early;
    input       late;
    input [2:0] amt;
    begin
      if (early && !late)
        pc_tap = 4'd`FDI_PC_NOM - {1'b0, amt};
      else if (late && !early)
        pc_tap = 4'd`FDI_PC_NOM + {1'b0, amt};
      else
        pc_tap = 4'd`FDI_PC_NOM;
    end
  endfunction

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  reg [4:0] meta_r;
  reg [4:0] sync_r;
  reg       pwr_meta_r;
  reg       pwr_sync_r;

  always @(posedge mclk)
  begin
    if (reset)
    begin
      meta_r     <= 5'h1f;
      sync_r     <= 5'h1f;
      pwr_meta_r <= 1'b0;
      pwr_sync_r <= 1'b0;
    end
    else
    begin
      meta_r     <= {rdata_n_in, door_changed_in, wprot_n_in,
                     track_zero_in, index_n_in};
      sync_r     <= meta_r;
      pwr_meta_r <= power_ok;
      pwr_sync_r <= pwr_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // control registers held on the drive side
  // ---------------------------------------------------------------
  reg [7:0] dor_r;
  reg [1:0] rate_r;

  always @(posedge mclk)
  begin
    if (reset)
    begin
      dor_r  <= `FDI_DOR_RST;
      rate_r <= `FDI_RATE_RST;
    end
    else
    begin
      if (dor_wr)
        dor_r <= dor_data;
      // the later write wins; a same-cycle pair takes the rate select
      if (dsr_wr)
        rate_r <= dsr_data[1:0];
      else if (ccr_wr)
        rate_r <= ccr_data[1:0];
    end
  end

  wire high_dens = (rate_r == `FDI_RATE_500K) ||
                   (rate_r == `FDI_RATE_1M);

  // ---------------------------------------------------------------
  // seek sequencer
  // ---------------------------------------------------------------
  reg [2:0]  sk_state_r;
  reg [7:0]  sk_left_r;
  reg [31:0] sk_cnt_r;
  reg        sk_in_r;

  always @(posedge mclk)
  begin
    if (reset)
    begin
      sk_state_r <= SK_IDLE;
      sk_left_r  <= 8'h00;
      sk_cnt_r   <= 32'h0;
      sk_in_r    <= 1'b0;
    end
    else
    begin
      case (sk_state_r)
        SK_IDLE:
          if (seek_go && seek_steps != 8'h00 && !rw_active)
          begin
            sk_in_r    <= seek_inward;
            sk_left_r  <= seek_steps;
            sk_cnt_r   <= STEP_PW_CYC - 1;
            sk_state_r <= SK_PULSE;
          end
        SK_PULSE:
          if (sk_cnt_r == 32'h0)
          begin
            sk_left_r  <= sk_left_r - 8'h01;
            sk_cnt_r   <= gap_cycles(step_rate) - 32'h1;
            sk_state_r <= SK_GAP;
          end
          else
            sk_cnt_r <= sk_cnt_r - 32'h1;
        SK_GAP:
          if (sk_cnt_r == 32'h0)
          begin
            if (sk_left_r == 8'h00)
              sk_state_r <= SK_IDLE;
            else
            begin
              sk_cnt_r   <= STEP_PW_CYC - 1;
              sk_state_r <= SK_PULSE;
            end
          end
          else
            sk_cnt_r <= sk_cnt_r - 32'h1;
        default:
          sk_state_r <= SK_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // write path: precompensation delay line and guarded gate
  // ---------------------------------------------------------------
  reg [15:0] flux_dl_r;
  reg [31:0] hold_r;
  wire       armed = (hold_r == 32'h0);

  always @(posedge mclk)
  begin
    if (reset)
    begin
      flux_dl_r <= 16'h0;
      hold_r    <= PWR_HOLD_CYC;
    end
    else
    begin
      flux_dl_r <= {flux_dl_r[14:0], wr_flux};
      // power must stay good for the hold time before any write
      if (!pwr_sync_r)
        hold_r <= PWR_HOLD_CYC;
      else if (!armed)
        hold_r <= hold_r - 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // output flip-flops
  // ---------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (reset)
    begin
      density_select_out  <= 1'b0;
      rate_bit_out        <= 1'b0;
      drive_select_first  <= 1'b1;
      drive_select_second <= 1'b1;
      motor_on_first      <= 1'b1;
      motor_on_second     <= 1'b1;
      side_select_out     <= 1'b1;
      dir_n_out           <= 1'b1;
      step_n_out          <= 1'b1;
      write_enable_out    <= 1'b1;
      wdata_n_out         <= 1'b1;
      seek_busy           <= 1'b0;
      index_sync          <= 1'b0;
      track_zero_sync     <= 1'b0;
      wprot_sync          <= 1'b0;
      input_reg           <= 8'h00;
      separator_gate_diag <= 1'b0;
      rdata_sync          <= 1'b0;
    end
    else
    begin
      density_select_out  <= high_dens ^
                             cfg_reg[`FDI_CFG_DPOL_BIT];
      rate_bit_out        <= rate_r[0];
      drive_select_first  <= ~dor_r[`FDI_DOR_SEL0_BIT];
      drive_select_second <= ~dor_r[`FDI_DOR_SEL1_BIT];
      motor_on_first      <= ~dor_r[`FDI_DOR_MOTOR_ON_FIRST_BIT];
      motor_on_second     <= ~dor_r[`FDI_DOR_MOTOR_ON_SECOND_BIT];
      side_select_out     <= ~head_side;
      // direction only asserted for an inward seek, never in transfers
      dir_n_out  <= ~(sk_in_r && sk_state_r != SK_IDLE &&
                      !rw_active);
      step_n_out <= ~(sk_state_r == SK_PULSE);
      seek_busy  <= (sk_state_r != SK_IDLE);
      write_enable_out <= ~(write_enable_out_req && armed &&
                            pwr_sync_r);
      wdata_n_out <= ~flux_dl_r[pc_tap(pc_early, pc_late,
                                       pc_amount)];
      index_sync      <= ~sync_r[0];
      track_zero_sync <= ~sync_r[1];
      wprot_sync      <= ~sync_r[2] | force_wp;
      // door input feeds either the register or the diagnostic gate
      input_reg <= {~sync_r[3] & ~diag_mode, 7'h00};
      separator_gate_diag <= ~sync_r[3] & diag_mode;
      rdata_sync <= ~sync_r[4];
    end
  end

endmodule

// ---- fdi_drive_model.sv ----
// behavioural floppy drive: head position, index and raw data
`timescale 1ns/10ps
module fdi_drive_model (
  input  wire mclk,
  input  wire step_n,
  input  wire dir_n,
  output reg  index_n = 1'h1,
  output reg  track_zero_n = 1'h0,
  output reg  rdata_n = 1'h1
);
  integer trk = 0;
  integer cnt = 0;
  reg     last = 1'h1;
  always @(negedge mclk)
  begin
    // head moves when the step pulse ends
    if (step_n && !last)
      trk = dir_n ? (trk > 0 ? trk - 1 : 0) : trk + 1;
    last = step_n;
    cnt = cnt + 1;
    index_n <= cnt % 64 != 0;
    rdata_n <= cnt % 3 != 0;
    track_zero_n <= trk != 0;
  end
endmodule

// ---- fdi_drive_if_assertions.sv ----
// port-level checks on the drive interface
`timescale 1ns/10ps
module fdi_drive_if_assertions (
  input wire       mclk, reset, dor_wr, ccr_wr, dsr_wr, head_side,
  input wire       rw_active, write_enable_out_req, power_ok, wr_flux, pc_early,
  input wire       pc_late, seek_go, seek_busy, step_n_out, dir_n_out,
  input wire       drive_select_first, drive_select_second,
  input wire       motor_on_first, motor_on_second, side_select_out,
  input wire       write_enable_out, rate_bit_out, wdata_n_out,
  input wire [7:0] dor_data, ccr_data, dsr_data, seek_steps
);
  wire [3:0] pins = {motor_on_second, motor_on_first, drive_select_second,
                     drive_select_first};
  wire [3:0] fld  = ~{dor_data[5:4], dor_data[1:0]};
  wire       rsrc = dsr_wr ? dsr_data[0] : ccr_data[0];
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_dor; dor_wr |=> ##1 pins == $past(fld, 2); endproperty
  a_dor: assert property (p_dor) else $error("select or motor");
  property p_side;
    !$past(reset) |-> side_select_out == !$past(head_side);
  endproperty
  a_side: assert property (p_side) else $error("side select");
  property p_dir; rw_active |=> dir_n_out; endproperty
  a_dir: assert property (p_dir) else $error("direction in rw");
  property p_step; $fell(step_n_out) |-> ##250 $rose(step_n_out); endproperty
  a_step: assert property (p_step) else $error("step width");
  property p_seek;
    seek_go && !seek_busy && !rw_active && seek_steps != 8'h0
      |-> ##2 !step_n_out && seek_busy;
  endproperty
  a_seek: assert property (p_seek) else $error("seek start");
  property p_wg;
    !write_enable_out |-> $past(write_enable_out_req) && $past(power_ok, 3);
  endproperty
  a_wg: assert property (p_wg) else $error("write gate");
  property p_rate;
    ccr_wr || dsr_wr |=> ##1 rate_bit_out == $past(rsrc, 2);
  endproperty
  a_rate: assert property (p_rate) else $error("rate bit");
  property p_flux; wr_flux && pc_early == pc_late |-> ##10 !wdata_n_out;
  endproperty
  a_flux: assert property (p_flux) else $error("write data");
  c_step: cover property ($fell(step_n_out));
  c_flux: cover property (!wdata_n_out);
  c_gate: cover property (!write_enable_out);
endmodule

bind fdi_drive_if fdi_drive_if_assertions u_fdi_drive_if_assertions (.*);

// ---- fdi_drive_if_tb.sv ----
// self-checking bench for the drive-side signal logic
`timescale 1ns/10ps
module fdi_drive_if_tb;
  reg        mclk = 0, reset = 1, dor_wr = 0, ccr_wr = 0, dsr_wr = 0;
  reg        seek_go = 0, wr_flux = 0, force_wp = 0, diag_mode = 0;
  reg        seek_inward = 0, rw_active = 0, head_side = 0, write_enable_out_req = 0;
  reg        pc_early = 0, pc_late = 0, power_ok = 0, wprot_n_in = 1;
  reg        door_changed_in = 1;
  reg  [7:0] dor_data = 0, cfg_reg = 0, ccr_data = 0, dsr_data = 0;
  reg  [7:0] seek_steps = 8'h2;
  reg  [3:0] step_rate = 4'hf;
  reg  [2:0] pc_amount = 3'h3;
  wire       index_n_in, track_zero_in, rdata_n_in, density_select_out;
  wire       rate_bit_out, drive_select_first, drive_select_second;
  wire       motor_on_first, motor_on_second, side_select_out, dir_n_out;
  wire       step_n_out, write_enable_out, wdata_n_out, seek_busy;
  wire       index_sync, track_zero_sync, wprot_sync, separator_gate_diag;
  wire       rdata_sync;
  wire [7:0] input_reg;
  integer    errors = 0, checked = 0, seed = 70, cyc = 0, i, k, nstep = 0;
  // pin history: synced outputs trail the pins by two edges
  reg  [1:0] pin_q[$];
  reg  [1:0] pin_want = 2'h0;

  fdi_drive_if #(.STEP_MS_CYC(10), .PWR_HOLD_CYC(4)) u_fdi_drive_if (.*);
  fdi_drive_model u_fdi_drive_model (.mclk(mclk), .step_n(step_n_out),
    .dir_n(dir_n_out), .index_n(index_n_in), .track_zero_n(track_zero_in),
    .rdata_n(rdata_n_in));

  always #2 mclk = ~mclk;
  always @(negedge step_n_out) nstep = nstep + 1;
  always @(posedge mclk)
  begin
    pin_q.push_back({~index_n_in, ~rdata_n_in});
    if (pin_q.size() > 2)
      pin_want <= pin_q.pop_front();
  end
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 4000)
    begin
      errors = errors + 1;
      close_out;
    end
  end

  task tick(input integer n);
    repeat (n) @(negedge mclk);
  endtask

  task chk(input [7:0] seen, input [7:0] want, input string what);
    begin
      checked = checked + 1;
      if (seen !== want)
      begin
        errors = errors + 1;
        $display("unexpected %s expected %h seen %h", what, want, seen);
      end
    end
  endtask

  task close_out;
    begin
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task seek(input inward);
    begin
      seek_inward = inward;
      seek_go = 1;
      tick(1);
      seek_go = 0;
      tick(3);
      chk(dir_n_out, !inward, "direction");
      rw_active = 1;
      tick(2);
      chk(dir_n_out, 1, "direction");
      rw_active = 0;
      for (k = 0; k < 900 && seek_busy; k = k + 1)
        tick(1);
      chk(seek_busy, 0, "busy");
      chk(k == 2 * (250 + 10 * (16 - step_rate)) - 4, 1, "seek time");
    end
  endtask

  // ----------------------------
  // main sequence
  // ----------------------------
  initial
  begin
    tick(10);
    chk(write_enable_out, 1, "write gate");
    chk({motor_on_second, motor_on_first, drive_select_second,
      drive_select_first}, 8'h0f, "selects");
    reset = 0;
    for (i = 0; i < 6; i = i + 1)
    begin
      k = $random(seed);
      dor_data = k[7:0];
      dor_wr = 1;
      tick(1);
      dor_wr = 0;
      tick(2);
      chk({motor_on_second, motor_on_first, drive_select_second,
        drive_select_first}, {~k[5:4], ~k[1:0]}, "selects");
    end
    for (i = 0; i < 8; i = i + 1)
    begin
      cfg_reg = {2'h0, i[2], 5'h0};
      ccr_data = {6'h0, i[1:0]};
      dsr_data = ccr_data;
      ccr_wr = i[0];
      dsr_wr = !i[0];
      tick(1);
      ccr_wr = 0;
      dsr_wr = 0;
      tick(2);
      chk(rate_bit_out, i[0], "rate bit");
      chk(density_select_out, (i[1] == i[0]) ^ i[2], "density");
    end
    head_side = 1;
    tick(2);
    chk(side_select_out, 0, "side");
    $display("register test done");
    seek(1);
    chk(track_zero_sync, 0, "track zero");
    step_rate = 4'he;
    seek(0);
    chk(nstep, 4, "step count");
    chk(track_zero_sync, 1, "track zero");
    $display("seek test done");
    door_changed_in = 0;
    tick(4);
    chk(input_reg, 8'h80, "input reg");
    diag_mode = 1;
    tick(2);
    chk(input_reg, 8'h0, "input reg");
    chk(separator_gate_diag, 1, "gate diag");
    chk(wprot_sync, 0, "protect");
    wprot_n_in = 0;
    tick(4);
    chk(wprot_sync, 1, "protect");
    wprot_n_in = 1;
    force_wp = 1;
    tick(4);
    chk(wprot_sync, 1, "protect");
    for (i = 0; i < 70; i = i + 1)
    begin
      tick(1);
      chk(index_sync, pin_want[1], "index");
      chk(rdata_sync, pin_want[0], "read data");
    end
    $display("input test done");
    power_ok = 1;
    write_enable_out_req = 1;
    tick(12);
    chk(write_enable_out, 0, "write gate");
    for (i = 0; i < 3; i = i + 1)
    begin
      pc_late = i[0];
      pc_early = i[1];
      wr_flux = 1;
      tick(1);
      wr_flux = 0;
      tick(i == 2 ? 6 : 9 + 3 * i);
      chk(wdata_n_out, 0, "write data");
      tick(1);
      chk(wdata_n_out, 1, "write data");
      tick(8);
    end
    power_ok = 0;
    tick(4);
    chk(write_enable_out, 1, "write gate");
    $display("write test done");
    close_out;
  end
endmodule
